// [rtl/asrc_defines.vh]
// timing constants and field sizes for the static memory host controller
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH

// ********************************************************************
// array geometry
// ********************************************************************
`define ASRC_ADDR_W            16
`define ASRC_DATA_W            4

// ********************************************************************
// clock and device timing, slowest speed grade, in ns
// ********************************************************************
`define ASRC_CLK_PERIOD_NS     40
// read_cycle_time
`define ASRC_READ_CYCLE_NS     45
// address_access_time and select_access_time
`define ASRC_ACCESS_NS         45
// write_cycle_time
`define ASRC_WRITE_CYCLE_NS    35
// select_to_write_end and address_to_write_end
`define ASRC_SEL_TO_WEND_NS    25
// write_pulse_width_b
`define ASRC_WRITE_PULSE_NS    25
// data_setup_time
`define ASRC_DATA_SETUP_NS     20
// deselect_to_float_time
`define ASRC_FLOAT_NS          18
// retention_recovery_time equals read_cycle_time
`define ASRC_RECOVERY_NS       45

// ********************************************************************
// derived cycle counts: least times round up, none below one
// ********************************************************************
`define ASRC_CEIL_CYC(ns)      (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_ACCESS_CYC        (`ASRC_CEIL_CYC(`ASRC_ACCESS_NS) + 1)
// strobe low must cover pulse width, select lead and data setup at once
`define ASRC_MAX(a, b)         (((a) > (b)) ? (a) : (b))
`define ASRC_WLOW_A_NS         `ASRC_MAX(`ASRC_WRITE_PULSE_NS, `ASRC_SEL_TO_WEND_NS)
`define ASRC_WLOW_NS           `ASRC_MAX(`ASRC_WLOW_A_NS, `ASRC_DATA_SETUP_NS)
`define ASRC_WPULSE_CYC        `ASRC_CEIL_CYC(`ASRC_WLOW_NS)
`define ASRC_GAP_CYC           `ASRC_CEIL_CYC(`ASRC_FLOAT_NS)
`define ASRC_RECOVERY_CYC      `ASRC_CEIL_CYC(`ASRC_RECOVERY_NS)
`define ASRC_CNT_W             4

`endif

// [rtl/asrc_sync_hold.v]
// small register stage that samples the memory data pins
`include "asrc_defines.vh"

module asrc_sync_hold (
  // clock and reset
  input  wire                     i_clk,
  input  wire                     i_arst_n,
  // capture control
  input  wire                     i_load,
  input  wire [`ASRC_DATA_W-1:0]  i_d,
  // held value
  output reg  [`ASRC_DATA_W-1:0]  o_q
);

  // capture only on load so the value survives later pin activity
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_q <= {`ASRC_DATA_W{1'b0}};
    end else if (i_load) begin
      o_q <= i_d;
    end
  end

endmodule // asrc_sync_hold

// [rtl/asrc_host.v]
// host controller driving an asynchronous 64k x 4 static memory
`include "asrc_defines.vh"

module asrc_host (
  // clock and reset
  input  wire                     i_clk,
  input  wire                     i_arst_n,
  // user request port
  input  wire                     i_req,
  input  wire                     i_we,
  input  wire [`ASRC_ADDR_W-1:0]  i_addr,
  input  wire [`ASRC_DATA_W-1:0]  i_wdata,
  output reg                      o_busy,
  output reg                      o_done,
  output wire [`ASRC_DATA_W-1:0]  o_rdata,
  // retention control
  input  wire                     i_retain,
  output reg                      o_retained,
  // memory pins
  output reg  [`ASRC_ADDR_W-1:0]  o_mem_addr,
  output reg                      o_mem_ce_n,
  output reg                      o_mem_we_n,
  output reg  [`ASRC_DATA_W-1:0]  o_mem_dq_o,
  output reg                      o_mem_dq_oe,
  input  wire [`ASRC_DATA_W-1:0]  i_mem_dq_i
);

  // ******************************************************************
  // states and counts
  // ******************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_END   = 3'h4;
  localparam [2:0] ST_GAP   = 3'h5;
  localparam [2:0] ST_RET   = 3'h6;

  // counts worked out as integers, then cut to the counter on purpose
  localparam integer ACC_CYC_I = `ASRC_ACCESS_CYC;
  localparam integer WP_CYC_I  = `ASRC_WPULSE_CYC;
  localparam integer GAP_CYC_I = `ASRC_GAP_CYC;
  localparam integer REC_CYC_I = `ASRC_RECOVERY_CYC;

  // all counts fit four bits at 25 MHz, so the cut loses nothing
  localparam [`ASRC_CNT_W-1:0] ACC_CYC = ACC_CYC_I[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] WP_CYC  = WP_CYC_I[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] GAP_CYC = GAP_CYC_I[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] REC_CYC = REC_CYC_I[`ASRC_CNT_W-1:0];

  reg [2:0]              state_r;
  reg [2:0]              state_nxt;
  reg [`ASRC_CNT_W-1:0]  cnt_r;
  reg [`ASRC_CNT_W-1:0]  cnt_nxt;
  reg                    wr_r;
  reg                    rd_load;
  // one request taken per idle edge
  wire                   accept;

  // ******************************************************************
  // read data capture
  // ******************************************************************
  asrc_sync_hold u_hold (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_load   (rd_load),
    .i_d      (i_mem_dq_i),
    .o_q      (o_rdata)
  );

  // ******************************************************************
  // request acceptance
  // ******************************************************************
  // retention wins over a request in the same edge
  assign accept = (state_r == ST_IDLE) && !i_retain && i_req;

  // ******************************************************************
  // next state
  // ******************************************************************
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rd_load   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (i_retain) begin
          // fresh count, not whatever the gap left behind
          state_nxt = ST_RET;
          cnt_nxt   = REC_CYC;
        end else if (i_req) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_nxt = wr_r ? ST_WRITE : ST_READ;
        cnt_nxt   = wr_r ? WP_CYC : ACC_CYC;
      end
      ST_READ: begin
        if (cnt_r <= 4'h1) begin
          // last select cycle: memory data has long settled
          rd_load   = 1'b1;
          state_nxt = ST_END;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_WRITE: begin
        if (cnt_r <= 4'h1) begin
          state_nxt = ST_END;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_END: begin
        state_nxt = ST_GAP;
        cnt_nxt   = GAP_CYC;
      end
      ST_GAP: begin
        if (cnt_r <= 4'h1) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_RET: begin
        if (i_retain) begin
          cnt_nxt = REC_CYC;
        end else if (cnt_r <= 4'h1) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ******************************************************************
  // state and counter registers
  // ******************************************************************
  // request kind captured only on accept, so request lines that move
  // during an access cannot turn a read into a write half way
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= {`ASRC_CNT_W{1'b0}};
      wr_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (accept) begin
        wr_r <= i_we;
      end
    end
  end

  // ******************************************************************
  // handshake registers
  // ******************************************************************
  // busy and retained taken from the next state so they line up with the pins, done from the current state
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_retained <= 1'b0;
    end else begin
      o_busy     <= (state_nxt != ST_IDLE);
      o_retained <= (state_nxt == ST_RET);
      o_done     <= (state_r == ST_END);
    end
  end

  // ******************************************************************
  // memory pin registers
  // ******************************************************************
  // every pin is a flop: no decode glitch ever reaches the memory
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_addr  <= {`ASRC_ADDR_W{1'b0}};
      o_mem_ce_n  <= 1'b1;
      o_mem_we_n  <= 1'b1;
      o_mem_dq_o  <= {`ASRC_DATA_W{1'b0}};
      o_mem_dq_oe <= 1'b0;
    end else begin
      // address and nibble set before select
      if (accept) begin
        o_mem_addr <= i_addr;
        o_mem_dq_o <= i_wdata;
      end
      o_mem_ce_n  <= !(state_nxt == ST_READ || state_nxt == ST_WRITE);
      o_mem_we_n  <= !(state_nxt == ST_WRITE);
      // drive pins only while strobe low
      o_mem_dq_oe <= (state_nxt == ST_WRITE);
    end
  end

endmodule // asrc_host

// [sim/asrc_host_properties.sv]
// assertions on the memory pins and handshake flags of the host controller
`include "asrc_defines.vh"
module asrc_host_properties (
  // watched ports
  input wire logic                    i_clk,
  input wire logic                    i_arst_n,
  input wire logic                    o_done,
  input wire logic                    o_retained,
  input wire logic [`ASRC_ADDR_W-1:0] o_mem_addr,
  input wire logic                    o_mem_ce_n,
  input wire logic                    o_mem_we_n,
  input wire logic                    o_mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_strobe_sel: assert property (!o_mem_we_n |-> !o_mem_ce_n) else $error("lone strobe");
  a_host_drive: assert property (o_mem_dq_oe |-> !o_mem_we_n) else $error("drive on read");
  a_data_write: assert property (!o_mem_we_n |-> o_mem_dq_oe) else $error("no data");
  a_addr_lead: assert property ($fell(o_mem_ce_n) |-> $stable(o_mem_addr)) else $error("a");
  a_addr_held: assert property (!o_mem_ce_n |=> $stable(o_mem_addr)) else $error("addr");
  a_write_end: assert property ($rose(o_mem_we_n) |-> $rose(o_mem_ce_n)) else $error("end");
  a_read_long: assert property ($fell(o_mem_ce_n) && o_mem_we_n |-> !o_mem_ce_n[*3])
    else $error("short read");
  a_float_gap: assert property ($rose(o_mem_ce_n) |=> o_mem_ce_n) else $error("no gap");
  a_retain_off: assert property (o_retained |-> o_mem_ce_n) else $error("selected");
  a_done_pulse: assert property (o_done |=> !o_done) else $error("long done");
  // main scenarios reached
  c_read: cover property ($fell(o_mem_ce_n) && o_mem_we_n);
  c_write: cover property (!o_mem_we_n);
  c_retain: cover property (o_retained);
endmodule // asrc_host_properties

// [sim/asrc_mem_model.sv]
// behavioural model of the 64k x 4 static memory
module asrc_mem_model #(
  parameter int ACC_NS = 45
) (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_dq_oe,
  input  wire logic [3:0]  i_dq_host,
  output logic [3:0]       o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem_r [0:65535];
  logic [3:0] junk_r = 4'h5;
  wire        drv;
  // slow to drive, quick to float
  assign #(ACC_NS, 8) drv = !i_ce_n && i_we_n;
  // released bus toggles so stale data never passes
  always @(posedge i_clk) junk_r <= ~junk_r;
  // store while select and strobe overlap
  always @* if (!i_ce_n && !i_we_n) mem_r[i_addr] = i_dq_oe ? i_dq_host : junk_r;
  assign o_dq = i_dq_oe ? i_dq_host : drv ? mem_r[i_addr] : junk_r;
endmodule // asrc_mem_model

// [sim/testbench.sv]
// self-checking bench for the static memory host controller
`include "asrc_defines.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // user side and memory pins
  logic        i_clk = 0, i_arst_n = 0, i_req = 0, i_we = 0, i_retain = 0;
  logic [15:0] i_addr = '0, a;
  logic [3:0]  i_wdata = '0, shadow [int];
  wire  [15:0] o_mem_addr;
  wire  [3:0]  o_rdata, o_mem_dq_o, i_mem_dq_i;
  wire         o_busy, o_done, o_retained, o_mem_ce_n, o_mem_we_n, o_mem_dq_oe;
  integer      seed = 11409, err_total = 0, n_checks = 0, n;
  asrc_host uut (.i_clk, .i_arst_n, .i_req, .i_we, .i_addr, .i_wdata, .o_busy, .o_done,
    .o_rdata, .i_retain, .o_retained, .o_mem_addr, .o_mem_ce_n, .o_mem_we_n, .o_mem_dq_o,
    .o_mem_dq_oe, .i_mem_dq_i);
  asrc_mem_model mem (.i_clk, .i_addr(o_mem_addr), .i_ce_n(o_mem_ce_n), .i_we_n(o_mem_we_n),
    .i_dq_oe(o_mem_dq_oe), .i_dq_host(o_mem_dq_o), .o_dq(i_mem_dq_i));
  // expected edges from accept to done: setup, select span, end
  function automatic integer exp_latency(input logic we);
    exp_latency = 2 + (we ? `ASRC_WPULSE_CYC : `ASRC_ACCESS_CYC);
  endfunction
  // one access, answer time counted from the accepting edge
  task automatic access(input logic we, input logic [15:0] ad, input logic [3:0] wd);
    @(posedge i_clk) begin i_req <= 1'b1; i_we <= we; i_addr <= ad; i_wdata <= wd; end
    @(posedge i_clk) i_req <= 1'b0;
    n = 0;
    do begin @(posedge i_clk); #1; n++; end while (o_done !== 1'b1 && n < 20);
    `CHK("latency", exp_latency(we), n)
    if (we) shadow[ad] = wd;
    else `CHK("rdata", shadow[ad], o_rdata)
    while (o_busy !== 1'b0 && n < 40) begin @(posedge i_clk); #1; n++; end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #20 i_clk = ~i_clk;
  // watchdog well beyond the few hundred cycles needed
  initial begin
    #(40 * 4000);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    `CHK("reset pins", 7'h60, {o_mem_ce_n, o_mem_we_n, o_mem_dq_oe, o_rdata})
    i_arst_n <= 1'b1;
    // corner addresses, then random write and read back pairs
    access(1, 16'h0000, 4'h5);
    access(1, 16'hffff, 4'ha);
    for (int k = 0; k < 12; k++) begin
      a = 16'($random(seed));
      access(1, a, 4'($random(seed)));
      access(0, a, 4'h0);
    end
    access(0, 16'h0000, 4'h0);
    $display("test read write done");
    // one-edge retention still gets the whole recovery count
    @(posedge i_clk) i_retain <= 1'b1;
    @(posedge i_clk) i_retain <= 1'b0;
    @(posedge i_clk);
    #1 `CHK("short recovery", 1'b1, o_retained)
    // requests refused while retention is asked for, busy meanwhile
    @(posedge i_clk) begin i_retain <= 1; i_req <= 1; i_we <= 1; i_wdata <= 4'hf; end
    repeat (6) @(posedge i_clk);
    #1 `CHK("retain", 3'h7, {o_retained, o_busy, o_mem_ce_n})
    @(posedge i_clk) begin i_retain <= 0; i_req <= 0; end
    repeat (4) @(posedge i_clk);
    access(0, 16'h0000, 4'h0);
    $display("test retention done");
    // contents survive a reset in mid-run, the memory has none
    @(posedge i_clk) i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK("rerst pins", 3'h6, {o_mem_ce_n, o_mem_we_n, o_mem_dq_oe})
    `CHK("rerst flags", 3'h0, {o_busy, o_done, o_retained})
    i_arst_n <= 1'b1;
    access(0, 16'hffff, 4'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule // testbench
bind asrc_host asrc_host_properties chk (.i_clk, .i_arst_n, .o_done, .o_retained, .o_mem_addr,
  .o_mem_ce_n, .o_mem_we_n, .o_mem_dq_oe);
